/* srp_pkg.sv */
// constants for the serial output port and host register block
// assumes one master clock domain; all host and serial pins are asynchronous to it
package srp_pkg;
  // external host register map, 3-bit address
  localparam logic [2:0] EXT_DATA_LOW = 3'h0;
  localparam logic [2:0] EXT_DATA_MIDDLE = 3'h1;
  localparam logic [2:0] EXT_DATA_TOP = 3'h2;
  localparam logic [2:0] EXT_POWER_DOWN = 3'h3;
  localparam logic [2:0] EXT_HW_SYNC = 3'h4;
  localparam logic [2:0] EXT_SW_SYNC = 3'h5;
  localparam logic [2:0] EXT_CHAN_POINTER = 3'h6;
  localparam logic [2:0] EXT_ACCESS_CONTROL = 3'h7;
  localparam int HOST_W = 8;
  localparam int ADDR_W = 3;
  localparam int ACR_AUTO_INC = 7;
  localparam int ACR_BROADCAST = 6;
  localparam int CHAN_DATA_W = 20;
  localparam int CHAN_ADDR_W = 8;
  localparam int CHAN_DEPTH = 256;
  // channel address space
  localparam logic [7:0] CH_SELF_TEST_I = 8'ha5;
  localparam logic [7:0] CH_SELF_TEST_Q = 8'ha6;
  localparam logic [7:0] CH_SERIAL_CTRL = 8'ha9;
  localparam int SPC_W = 10;
  localparam logic [9:0] SPC_RESET = 10'h000;
  localparam int SPC_MAP = 9;
  localparam int SPC_FS_LO = 7;
  localparam int SPC_WL_LO = 5;
  localparam int SPC_MASTER = 4;
  localparam int SPC_DIV_LO = 0;
  localparam logic [1:0] FS_PAIR = 2'h0;
  localparam logic [1:0] FS_FULL = 2'h1;
  localparam logic [5:0] WL_12 = 6'h0c;
  localparam logic [5:0] WL_16 = 6'h10;
  localparam logic [5:0] WL_24 = 6'h18;
  localparam int SAMPLE_W = 24;
  localparam int ST_W = 16;
  localparam logic [15:0] MISR_TAPS = 16'hb400;
  localparam int FIFO_DEPTH = 4;
  // asynchronous pin vector layout
  localparam int PIN_N = 9;
  localparam int P_CS = 0;
  localparam int P_STB = 1;
  localparam int P_DIR = 2;
  localparam int P_SCLK = 3;
  localparam int P_STRAP = 4;
  localparam int P_DIV = 5;
  localparam logic [8:0] PIN_IDLE = 9'h007;
  typedef enum logic [1:0] {ST_IDLE, ST_LEAD, ST_SHIFT} srp_state_t;
endpackage : srp_pkg

/* srp_serial_port.sv */
// serial output port, channel register space and 8-bit host register port
// assumes host address and write data are stable while the strobe is active
`timescale 1ns/1ps

module srp_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input wire logic clock,
  input wire logic reset,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int PW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0] wr_ptr_reg;
  logic [PW-1:0] rd_ptr_reg;
  logic [PW:0] count_reg;
  logic push;
  logic pop;

  assign in_ready = count_reg != (PW+1)'(DEPTH);
  assign out_valid = count_reg != '0;
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem[rd_ptr_reg];

  always_ff @(posedge clock)
  begin
    if (push)
      mem[wr_ptr_reg] <= in_data;
  end

  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end
    else
    begin
      if (push)
        wr_ptr_reg <= (wr_ptr_reg == PW'(DEPTH-1)) ? '0 : wr_ptr_reg + 1'b1;
      if (pop)
        rd_ptr_reg <= (rd_ptr_reg == PW'(DEPTH-1)) ? '0 : rd_ptr_reg + 1'b1;
      count_reg <= count_reg + (PW+1)'(push) - (PW+1)'(pop);
    end
  end
endmodule : srp_fifo

module srp_serial_port #(
  parameter int CHANNEL_INDEX = 1
) (
  input wire logic clock,
  input wire logic reset,
  input wire logic bus_style,
  input wire logic host_cs_n,
  input wire logic host_strobe_n,
  input wire logic host_dir,
  input wire logic [srp_pkg::ADDR_W-1:0] host_addr,
  input wire logic [srp_pkg::HOST_W-1:0] host_wdata,
  output logic [srp_pkg::HOST_W-1:0] host_rdata,
  output logic host_rdata_oe,
  output logic transfer_acknowledge,
  output logic [srp_pkg::HOST_W-1:0] power_down_control,
  output logic [srp_pkg::HOST_W-1:0] hardware_sync_enable,
  output logic [srp_pkg::HOST_W-1:0] software_sync_trigger,
  input wire logic sample_valid,
  output logic sample_ready,
  input wire logic [srp_pkg::SAMPLE_W-1:0] sample_i,
  input wire logic [srp_pkg::SAMPLE_W-1:0] sample_q,
  input wire logic sample_fixed_point,
  input wire logic port0_master_strap,
  input wire logic [3:0] port0_clock_divider_pins,
  input wire logic serial_clock_in,
  output logic serial_clock_out,
  output logic serial_clock_oe,
  output logic serial_data,
  output logic serial_data_oe,
  output logic serial_frame_sync,
  output logic channel_data_ready_pulse
);
  import srp_pkg::*;

  localparam int FW = 2 * SAMPLE_W + 1;

  logic [PIN_N-1:0] pin_raw;
  logic [PIN_N-1:0] pin_f;
  logic acc_active;
  logic acc_write;
  logic acc_prev_reg;
  logic acc_start;
  logic ack_reg;
  logic [7:0] acr_reg;
  logic [7:0] car_reg;
  logic [7:0] mid_reg;
  logic [3:0] top_reg;
  logic [7:0] sleep_reg;
  logic [7:0] hw_sync_reg;
  logic [7:0] sw_sync_reg;
  logic [11:0] rd_hold_reg;
  logic [7:0] rdata_reg;
  logic [SPC_W-1:0] spc_reg;
  logic [CHAN_DATA_W-1:0] chan_mem [CHAN_DEPTH];
  logic [CHAN_DATA_W-1:0] chan_word;
  logic [CHAN_DATA_W-1:0] wr_word;
  logic bcast;
  logic chan_hit;
  logic chan_we;
  logic low_access;
  logic is_master;
  logic [3:0] div_sel;
  logic [3:0] div_cnt_reg;
  logic tick_m;
  logic sclk_prev_reg;
  logic tick_s;
  logic bit_tick;
  logic sclk_out_reg;
  logic master_oe_reg;
  logic [1:0] fs_fmt;
  logic [5:0] word_len;
  logic [5:0] last_bit;
  logic fifo_valid;
  logic fifo_pop;
  logic [FW-1:0] fifo_data;
  logic [SAMPLE_W-1:0] i_fmt;
  logic [SAMPLE_W-1:0] q_fmt;
  srp_state_t state_reg;
  logic [5:0] bit_cnt_reg;
  logic [SAMPLE_W-1:0] i_sh_reg;
  logic [SAMPLE_W-1:0] q_sh_reg;
  logic data_reg;
  logic fs_reg;
  logic dr_reg;
  logic [ST_W-1:0] st_i_reg;
  logic [ST_W-1:0] st_q_reg;

  // fixed-point input rounds to the top len bits, other input truncates; positive overflow saturates instead of wrapping
  function automatic logic [SAMPLE_W-1:0] fmt_word(input logic [SAMPLE_W-1:0] x,
      input logic [5:0] len, input logic fixed);
    logic [SAMPLE_W-1:0] low;
    logic [SAMPLE_W-1:0] half;
    logic [SAMPLE_W-1:0] res;
    low = {SAMPLE_W{1'b1}} >> len;
    half = low ^ (low >> 1);
    res = x;
    if (fixed)
    begin
      res = x + half;
      if (!x[SAMPLE_W-1] && res[SAMPLE_W-1])
        res = {1'b0, {(SAMPLE_W-1){1'b1}}};
    end
    return res & ~low;
  endfunction : fmt_word

  function automatic logic [ST_W-1:0] misr(input logic [ST_W-1:0] s,
      input logic [ST_W-1:0] d);
    return {s[ST_W-2:0], ^(s & MISR_TAPS)} ^ d;
  endfunction : misr

  // three-stage synchronisers; a level is taken once stages two and three agree
  assign pin_raw = {port0_clock_divider_pins, port0_master_strap, serial_clock_in,
                    host_dir, host_strobe_n, host_cs_n};
  generate
    for (genvar g = 0; g < PIN_N; g++)
    begin : g_sync
      logic s1_reg;
      logic s2_reg;
      logic s3_reg;
      logic f_reg;
      always_ff @(posedge clock)
      begin
        if (reset)
        begin
          s1_reg <= PIN_IDLE[g];
          s2_reg <= PIN_IDLE[g];
          s3_reg <= PIN_IDLE[g];
          f_reg <= PIN_IDLE[g];
        end
        else
        begin
          s1_reg <= pin_raw[g];
          s2_reg <= s1_reg;
          s3_reg <= s2_reg;
          if (s2_reg == s3_reg)
            f_reg <= s3_reg;
        end
      end
      assign pin_f[g] = f_reg;
    end
  endgenerate

  // both bus styles: write is a low direction/write line while selected
  assign acc_active = !pin_f[P_CS] &&
      (bus_style ? !pin_f[P_STB] : (!pin_f[P_STB] || !pin_f[P_DIR]));
  assign acc_write = !pin_f[P_DIR];
  assign acc_start = acc_active && !acc_prev_reg;
  assign bcast = acr_reg[ACR_BROADCAST];
  assign chan_hit = bcast || (acr_reg[1:0] == 2'(CHANNEL_INDEX));
  assign low_access = acc_start && (host_addr == EXT_DATA_LOW);
  assign wr_word = {top_reg, mid_reg, host_wdata};
  assign chan_we = low_access && acc_write && chan_hit;

  always_comb
  begin
    case (car_reg)
      CH_SERIAL_CTRL: chan_word = CHAN_DATA_W'(spc_reg);
      CH_SELF_TEST_I: chan_word = CHAN_DATA_W'(st_i_reg);
      CH_SELF_TEST_Q: chan_word = CHAN_DATA_W'(st_q_reg);
      default: chan_word = chan_mem[car_reg];
    endcase
  end

  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      acc_prev_reg <= 1'b0;
      ack_reg <= 1'b0;
    end
    else
    begin
      acc_prev_reg <= acc_active;
      ack_reg <= acc_active && acc_prev_reg;
    end
  end

  // one decoder serves every host register read and write on the parallel port
  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      acr_reg <= '0;
      car_reg <= '0;
      mid_reg <= '0;
      top_reg <= '0;
      sleep_reg <= '0;
      hw_sync_reg <= '0;
      sw_sync_reg <= '0;
      rd_hold_reg <= '0;
      rdata_reg <= '0;
      spc_reg <= SPC_RESET;
    end
    else if (acc_start)
    begin
      if (acc_write)
      begin
        case (host_addr)
          EXT_ACCESS_CONTROL: acr_reg <= host_wdata;
          EXT_CHAN_POINTER: car_reg <= host_wdata;
          EXT_SW_SYNC: sw_sync_reg <= host_wdata;
          EXT_HW_SYNC: hw_sync_reg <= host_wdata;
          EXT_POWER_DOWN: sleep_reg <= host_wdata;
          EXT_DATA_TOP: top_reg <= host_wdata[3:0];
          EXT_DATA_MIDDLE: mid_reg <= host_wdata;
          default:
          begin
            if (chan_hit && car_reg == CH_SERIAL_CTRL)
              spc_reg <= wr_word[SPC_W-1:0];
            if (acr_reg[ACR_AUTO_INC])
              car_reg <= car_reg + 8'h01;
          end
        endcase
      end
      else
      begin
        case (host_addr)
          EXT_ACCESS_CONTROL: rdata_reg <= acr_reg;
          EXT_CHAN_POINTER: rdata_reg <= bcast ? '0 : car_reg;
          EXT_DATA_TOP: rdata_reg <= {4'h0, rd_hold_reg[11:8]};
          EXT_DATA_MIDDLE: rdata_reg <= rd_hold_reg[7:0];
          EXT_DATA_LOW:
          begin
            rdata_reg <= (bcast || !chan_hit) ? '0 : chan_word[7:0];
            rd_hold_reg <= (bcast || !chan_hit) ? '0 : chan_word[19:8];
            if (acr_reg[ACR_AUTO_INC])
              car_reg <= car_reg + 8'h01;
          end
          default: rdata_reg <= '0;
        endcase
      end
    end
  end

  always_ff @(posedge clock)
  begin
    if (chan_we && car_reg != CH_SERIAL_CTRL)
      chan_mem[car_reg] <= wr_word;
  end

  assign host_rdata = rdata_reg;
  assign host_rdata_oe = acc_active && !acc_write;
  assign transfer_acknowledge = ack_reg;
  assign power_down_control = sleep_reg;
  assign hardware_sync_enable = hw_sync_reg;
  assign software_sync_trigger = sw_sync_reg;

  // serial clocking; in slave mode data and frame sync change on the rising bit clock edge, in master mode one master clock before serial_clock_out rises
  assign is_master = (CHANNEL_INDEX == 0) ? pin_f[P_STRAP] : spc_reg[SPC_MASTER];
  assign div_sel = (CHANNEL_INDEX == 0) ? pin_f[P_DIV +: 4]
                                        : spc_reg[SPC_DIV_LO +: 4];
  assign tick_m = div_cnt_reg == div_sel;
  assign tick_s = pin_f[P_SCLK] && !sclk_prev_reg;
  assign bit_tick = is_master ? tick_m : tick_s;
  assign fs_fmt = spc_reg[SPC_FS_LO +: 2];
  assign word_len = spc_reg[SPC_WL_LO + 1] ? WL_24 : (spc_reg[SPC_WL_LO] ? WL_16 : WL_12);
  assign last_bit = (word_len << 1) - 6'h01;

  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      div_cnt_reg <= '0;
      sclk_prev_reg <= 1'b0;
      sclk_out_reg <= 1'b0;
      master_oe_reg <= 1'b0;
    end
    else
    begin
      div_cnt_reg <= tick_m ? 4'h0 : div_cnt_reg + 4'h1;
      sclk_prev_reg <= pin_f[P_SCLK];
      // high for the first half of each period; divide by one stays high
      sclk_out_reg <= ({1'b0, div_cnt_reg, 1'b0} < 6'(div_sel) + 6'h01);
      master_oe_reg <= is_master;
    end
  end

  assign serial_clock_out = sclk_out_reg;
  assign serial_clock_oe = master_oe_reg;

  srp_fifo #(.WIDTH(FW), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clock(clock),
    .reset(reset),
    .in_valid(sample_valid),
    .in_ready(sample_ready),
    .in_data({sample_fixed_point, sample_i, sample_q}),
    .out_valid(fifo_valid),
    .out_ready(fifo_pop),
    .out_data(fifo_data)
  );

  assign fifo_pop = (state_reg == ST_IDLE) && bit_tick;
  assign i_fmt = fmt_word(fifo_data[2*SAMPLE_W-1 -: SAMPLE_W], word_len, fifo_data[FW-1]);
  assign q_fmt = fmt_word(fifo_data[SAMPLE_W-1:0], word_len, fifo_data[FW-1]);

  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      state_reg <= ST_IDLE;
      bit_cnt_reg <= '0;
      i_sh_reg <= '0;
      q_sh_reg <= '0;
      data_reg <= 1'b0;
      fs_reg <= 1'b0;
    end
    else if (bit_tick)
    begin
      case (state_reg)
        ST_IDLE:
        begin
          data_reg <= 1'b0;
          fs_reg <= 1'b0;
          if (fifo_valid)
          begin
            i_sh_reg <= i_fmt;
            q_sh_reg <= q_fmt;
            fs_reg <= fs_fmt != FS_FULL;
            state_reg <= ST_LEAD;
          end
        end
        ST_LEAD:
        begin
          data_reg <= i_sh_reg[SAMPLE_W-1];
          i_sh_reg <= i_sh_reg << 1;
          fs_reg <= fs_fmt == FS_FULL;
          bit_cnt_reg <= '0;
          state_reg <= ST_SHIFT;
        end
        ST_SHIFT:
        begin
          if (bit_cnt_reg == last_bit)
          begin
            data_reg <= 1'b0;
            fs_reg <= 1'b0;
            state_reg <= ST_IDLE;
          end
          else
          begin
            bit_cnt_reg <= bit_cnt_reg + 6'h01;
            if (bit_cnt_reg + 6'h01 < word_len)
            begin
              data_reg <= i_sh_reg[SAMPLE_W-1];
              i_sh_reg <= i_sh_reg << 1;
            end
            else
            begin
              data_reg <= q_sh_reg[SAMPLE_W-1];
              q_sh_reg <= q_sh_reg << 1;
            end
            fs_reg <= (fs_fmt == FS_FULL) ||
                (fs_fmt[1] && bit_cnt_reg + 6'h02 == word_len);
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // ready pulse starts with the frame; in mapped mode it lasts one master clock
  always_ff @(posedge clock)
  begin
    if (reset)
      dr_reg <= 1'b0;
    else if (state_reg == ST_IDLE)
      dr_reg <= bit_tick && fifo_valid;
    else if (state_reg == ST_LEAD)
      dr_reg <= dr_reg && !spc_reg[SPC_MAP] && !bit_tick;
    else
      dr_reg <= 1'b0;
  end

  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      st_i_reg <= '0;
      st_q_reg <= '0;
    end
    else if (fifo_pop && fifo_valid)
    begin
      if (spc_reg[SPC_MAP])
      begin
        st_i_reg <= i_fmt[SAMPLE_W-1 -: ST_W];
        st_q_reg <= q_fmt[SAMPLE_W-1 -: ST_W];
      end
      else
      begin
        st_i_reg <= misr(st_i_reg, i_fmt[SAMPLE_W-1 -: ST_W]);
        st_q_reg <= misr(st_q_reg, q_fmt[SAMPLE_W-1 -: ST_W]);
      end
    end
  end

  assign serial_data = data_reg;
  assign serial_data_oe = state_reg != ST_IDLE;
  assign serial_frame_sync = fs_reg;
  assign channel_data_ready_pulse = dr_reg;

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (reset);

  a_map_capture: assert property ((fifo_pop && fifo_valid && spc_reg[SPC_MAP])
      |=> {st_i_reg, 8'h00} == ($past(i_fmt) & 24'hff_ff00))
    else $error("mapped self-test register missed the sample");
  a_ready_short: assert property ((dr_reg && spc_reg[SPC_MAP] && state_reg == ST_LEAD)
      |=> !dr_reg)
    else $error("mapped ready pulse longer than one clock");
  a_ready_long: assert property ((dr_reg && !spc_reg[SPC_MAP] && !bit_tick
      && state_reg == ST_LEAD) |=> dr_reg)
    else $error("unmapped ready pulse ended before the bit clock");
  a_pair_sync: assert property ((state_reg == ST_LEAD && fs_fmt == FS_PAIR) |-> fs_reg)
    else $error("pair frame sync missing before I word");
  a_full_sync: assert property ((state_reg == ST_SHIFT && fs_fmt == FS_FULL
      && $stable(spc_reg)) |-> fs_reg)
    else $error("frame sync dropped inside frame");
  a_dual_sync: assert property ((bit_tick && state_reg == ST_SHIFT && fs_fmt[1]
      && bit_cnt_reg + 6'h02 == word_len) |=> fs_reg)
    else $error("second frame sync missing before Q word");
  a_frame_end: assert property ((bit_tick && state_reg == ST_SHIFT
      && bit_cnt_reg == last_bit) |=> state_reg == ST_IDLE && !serial_data_oe)
    else $error("frame length wrong for word length");
  a_slave_start: assert property ($fell(reset) |-> !spc_reg[SPC_MASTER])
    else $error("port not slave after reset");
  a_auto_inc: assert property ((low_access && acr_reg[ACR_AUTO_INC])
      |=> car_reg == $past(car_reg) + 8'h01)
    else $error("pointer did not advance");
  a_bcast_read: assert property ((acc_start && !acc_write && bcast
      && host_addr == EXT_CHAN_POINTER) |=> host_rdata == 8'h00)
    else $error("pointer readback during broadcast");
  a_ack_follow: assert property (acc_start |-> ##1 (!acc_active or ##1 ack_reg))
    else $error("acknowledge missing after access");

  c_dual_frame: cover property (state_reg == ST_SHIFT && fs_fmt[1] && fs_reg);
  c_mapped_frame: cover property (dr_reg && spc_reg[SPC_MAP]);
  c_block_write: cover property (chan_we ##[1:50] chan_we);
  c_fifo_full: cover property (!sample_ready && sample_valid);
endmodule : srp_serial_port

/* srp_host_rx.sv */
// host serial port model: receives I/Q frames from the block's serial output
// assumes master mode at divide by one, so one bit per master clock
`timescale 1ns/1ps
module srp_host_rx (
  input wire logic clock,
  input wire logic reset,
  input wire logic active,
  input wire logic [1:0] fmt,
  input wire logic [5:0] len,
  input wire logic serial_data,
  input wire logic serial_frame_sync,
  input wire logic channel_data_ready_pulse,
  output logic serial_clock_in,
  output logic frame_done,
  output logic fs_bad,
  output logic [23:0] word_i,
  output logic [23:0] word_q
);
  int cnt;
  int pos;
  logic fs_exp;
  initial serial_clock_in = 1'b0;
  // the block is master here, so this line is undriven: keep it moving
  always @(posedge clock)
  begin
    serial_clock_in <= ~serial_clock_in;
    frame_done <= 1'b0;
    if (reset || !active)
      cnt <= 0;
    else if (cnt == 0)
    begin
      if (channel_data_ready_pulse)
      begin
        cnt <= 2 * len;
        word_i <= 24'h00_0000;
        word_q <= 24'h00_0000;
        fs_bad <= (serial_frame_sync !== (fmt != 2'h1));
      end
    end
    else
    begin
      pos = 2 * len - cnt;
      fs_exp = (fmt == 2'h1) || (fmt[1] && pos == len - 1);
      if (serial_frame_sync !== fs_exp)
        fs_bad <= 1'b1;
      if (pos < len)
        word_i <= {word_i[22:0], serial_data};
      else
        word_q <= {word_q[22:0], serial_data};
      cnt <= cnt - 1;
      frame_done <= (cnt == 1);
    end
  end
endmodule : srp_host_rx

/* test_serial_output_port_and_host_registers.sv */
// self-checking bench for the serial output port and host register block
// assumes channel index 1, so the channel zero strap and divider pins stay idle
`timescale 1ns/1ps
module test_serial_output_port_and_host_registers;
  import srp_pkg::*;
  logic clock, reset, bus_style, host_cs_n, host_strobe_n, host_dir, host_rdata_oe;
  logic transfer_acknowledge, sample_valid, sample_ready, sample_fixed_point;
  logic [2:0] host_addr;
  logic [7:0] host_wdata, host_rdata, power_down_control, hardware_sync_enable;
  logic [7:0] software_sync_trigger, q;
  logic [23:0] sample_i, sample_q, word_i, word_q;
  logic port0_master_strap, serial_clock_in, serial_clock_out, serial_clock_oe;
  logic serial_data, serial_data_oe, serial_frame_sync, channel_data_ready_pulse;
  logic [3:0] port0_clock_divider_pins;
  logic rx_active, frame_done, fs_bad, saw_full;
  logic [19:0] stw;
  logic [1:0] rx_fmt;
  logic [5:0] rx_len;
  logic [31:0] seed;
  logic [48:0] exp_q[$];
  logic [48:0] e;
  logic [19:0] mem[int];
  int n_fail, samples_checked;

  srp_serial_port #(.CHANNEL_INDEX(1)) dut (.clock(clock), .reset(reset),
    .bus_style(bus_style), .host_cs_n(host_cs_n), .host_strobe_n(host_strobe_n),
    .host_dir(host_dir), .host_addr(host_addr), .host_wdata(host_wdata),
    .host_rdata(host_rdata), .host_rdata_oe(host_rdata_oe),
    .transfer_acknowledge(transfer_acknowledge), .power_down_control(power_down_control),
    .hardware_sync_enable(hardware_sync_enable),
    .software_sync_trigger(software_sync_trigger), .sample_valid(sample_valid),
    .sample_ready(sample_ready), .sample_i(sample_i), .sample_q(sample_q),
    .sample_fixed_point(sample_fixed_point), .port0_master_strap(port0_master_strap),
    .port0_clock_divider_pins(port0_clock_divider_pins), .serial_clock_in(serial_clock_in),
    .serial_clock_out(serial_clock_out), .serial_clock_oe(serial_clock_oe),
    .serial_data(serial_data), .serial_data_oe(serial_data_oe),
    .serial_frame_sync(serial_frame_sync), .channel_data_ready_pulse(channel_data_ready_pulse));

  srp_host_rx rx (.clock(clock), .reset(reset), .active(rx_active), .fmt(rx_fmt),
    .len(rx_len), .serial_data(serial_data), .serial_frame_sync(serial_frame_sync),
    .channel_data_ready_pulse(channel_data_ready_pulse), .serial_clock_in(serial_clock_in),
    .frame_done(frame_done), .fs_bad(fs_bad), .word_i(word_i), .word_q(word_q));

  initial
  begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  // for fixed point round half up and clip positive overflow; keep the top len bits
  function automatic logic [23:0] fmtw(input logic [23:0] x, input int len, input logic fx);
    logic [24:0] r;
    r = {1'b0, x};
    if (fx && len < 24)
      r = r + (25'h000_0001 << (23 - len));
    if (fx && !x[23] && r[23])
      r = 25'h07f_ffff;
    return r[23:0] >> (24 - len);
  endfunction : fmtw

  task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic results;
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : results

  // style 0: read when strobe_n low, write when dir low; style 1: strobe_n low for both, dir low writes
  task automatic host(input logic wr, input logic [2:0] a, input logic [7:0] d);
    int t;
    host_addr <= a;
    host_wdata <= d;
    host_cs_n <= 1'b0;
    host_strobe_n <= bus_style ? 1'b0 : wr;
    host_dir <= !wr;
    t = 0;
    do @(posedge clock); while (transfer_acknowledge !== 1'b1 && ++t < 60);
    q = host_rdata;
    check("ack", transfer_acknowledge, 1'b1);
    check("rdata_oe", host_rdata_oe, !wr);
    {host_cs_n, host_strobe_n, host_dir} <= 3'h7;
    t = 0;
    do @(posedge clock); while (transfer_acknowledge !== 1'b0 && ++t < 60);
    @(posedge clock);
  endtask : host

  task automatic chw(input logic [19:0] w);
    host(1'b1, EXT_DATA_TOP, {4'h0, w[19:16]});
    host(1'b1, EXT_DATA_MIDDLE, w[15:8]);
    host(1'b1, EXT_DATA_LOW, w[7:0]);
  endtask : chw

  task automatic chr(output logic [19:0] w);
    host(1'b0, EXT_DATA_LOW, 8'h00);
    w[7:0] = q;
    host(1'b0, EXT_DATA_MIDDLE, 8'h00);
    w[15:8] = q;
    host(1'b0, EXT_DATA_TOP, 8'h00);
    w[19:16] = q[3:0];
  endtask : chr

  task automatic regs;
    logic [19:0] w;
    host(1'b1, EXT_ACCESS_CONTROL, 8'h81);
    host(1'b1, EXT_CHAN_POINTER, 8'h10);
    for (int k = 0; k < 2; k++)
    begin
      seed = lfsr(seed);
      mem[16 + k] = seed[19:0];
      chw(seed[19:0]);
    end
    host(1'b0, EXT_CHAN_POINTER, 8'h00);
    check("pointer_inc", q, 8'h12);
    host(1'b1, EXT_CHAN_POINTER, 8'h10);
    for (int k = 0; k < 2; k++)
    begin
      chr(w);
      check("chan_word", w, mem[16 + k]);
    end
    for (int a = 3; a < 6; a++)
    begin
      host(1'b1, a[2:0], 8'h5a + a[7:0]);
      host(1'b0, a[2:0], 8'h00);
      check("write_only", q, 8'h00);
    end
    check("power_down", power_down_control, 8'h5d);
    check("hw_sync", hardware_sync_enable, 8'h5e);
    check("sw_sync", software_sync_trigger, 8'h5f);
    host(1'b1, EXT_ACCESS_CONTROL, 8'h41);
    host(1'b0, EXT_CHAN_POINTER, 8'h00);
    check("bcast_ptr", q, 8'h00);
    host(1'b1, EXT_ACCESS_CONTROL, 8'h01);
    host(1'b0, EXT_ACCESS_CONTROL, 8'h00);
    check("access_ctrl", q, 8'h01);
  endtask : regs

  task automatic cfg(input logic [9:0] v);
    host(1'b1, EXT_CHAN_POINTER, CH_SERIAL_CTRL);
    chw({10'h000, v});
  endtask : cfg

  // own record, since the frame checker reuses e while a push is stalled
  task automatic push(input int n);
    int t;
    logic [48:0] v;
    for (int k = 0; k < n; k++)
    begin
      seed = lfsr(seed);
      sample_i <= seed[23:0];
      v[47:24] = seed[23:0];
      seed = lfsr(seed);
      sample_q <= seed[23:0];
      v[23:0] = seed[23:0];
      v[48] = seed[31];
      sample_fixed_point <= seed[31];
      sample_valid <= 1'b1;
      t = 0;
      do @(posedge clock); while (sample_ready !== 1'b1 && ++t < 400);
      if (t != 0)
        saw_full = 1'b1;
      exp_q.push_back(v);
    end
    sample_valid <= 1'b0;
  endtask : push

  task automatic measure(input logic mapped);
    int n;
    logic p;
    n = 0;
    while (channel_data_ready_pulse !== 1'b1 && ++n < 400)
      @(posedge clock);
    n = 0;
    while (channel_data_ready_pulse === 1'b1 && n < 20)
    begin
      @(posedge clock);
      n++;
    end
    check("ready_width", 24'(n), mapped ? 24'h00_0001 : 24'h00_0004);
    for (int k = 0; k < 2; k++)
    begin
      n = 0;
      do
      begin
        p = serial_clock_out;
        @(posedge clock);
        n++;
      end
      while (!(p === 1'b0 && serial_clock_out === 1'b1) && n < 40);
    end
    check("clock_period", 24'(n), 24'h00_0004);
  endtask : measure

  always @(posedge clock)
  begin
    if (frame_done)
    begin
      check("frame_expected", 24'(exp_q.size() == 0), 24'h00_0000);
      e = exp_q.pop_front();
      check("serial_i", word_i, fmtw(e[47:24], rx_len, e[48]));
      check("serial_q", word_q, fmtw(e[23:0], rx_len, e[48]));
      check("frame_sync", fs_bad, 1'b0);
      check("data_oe", serial_data_oe, 1'b0);
    end
  end

  initial
  begin
    repeat (50000) @(posedge clock);
    n_fail++;
    results();
  end

  initial
  begin
    {reset, bus_style, sample_valid, sample_fixed_point, rx_active, saw_full} = 6'h20;
    {host_cs_n, host_strobe_n, host_dir, host_addr, host_wdata} = {3'h7, 11'h000};
    {sample_i, sample_q, rx_fmt, rx_len} = {48'h0, 2'h0, WL_12};
    {port0_master_strap, port0_clock_divider_pins} = 5'h00;
    {n_fail, samples_checked, seed} = {32'h0, 32'h0, 32'h0001_1476};
    repeat (6) @(posedge clock);
    reset <= 1'b0;
    repeat (6) @(posedge clock);
    check("clock_oe", serial_clock_oe, 1'b0);
    check("ack_idle", transfer_acknowledge, 1'b0);
    for (int s = 0; s < 2; s++)
    begin
      bus_style <= s[0];
      @(posedge clock);
      regs();
    end
    rx_active <= 1'b1;
    for (int f = 0; f < 4; f++)
      for (int l = 0; l < 3; l++)
      begin
        cfg({1'b0, f[1:0], l[1:0], 1'b1, 4'h0});
        rx_fmt <= f[1:0];
        rx_len <= (l == 0) ? WL_12 : (l == 1) ? WL_16 : WL_24;
        push((f == 0 && l == 2) ? 6 : 2);
        for (int t = 0; t < 3000 && exp_q.size() != 0; t++)
          @(posedge clock);
        check("drained", 24'(exp_q.size()), 24'h00_0000);
      end
    check("fifo_full", saw_full, 1'b1);
    rx_active <= 1'b0;
    for (int m = 0; m < 2; m++)
    begin
      cfg({m[0], 2'h0, 2'h1, 1'b1, 4'h3});
      fork
        push(1);
        measure(m[0]);
      join
      repeat (300) @(posedge clock);
      if (m[0])
      begin
        host(1'b1, EXT_CHAN_POINTER, CH_SELF_TEST_I);
        chr(stw);
        check("self_test_i", stw, fmtw(exp_q[0][47:24], 16, exp_q[0][48]));
      end
      exp_q.delete();
    end
    results();
  end
endmodule : test_serial_output_port_and_host_registers
